//--- design/slave_ctrl_defs.vh
/*
 register offsets, field positions and reset values of the timer
 slave-mode controller; included by its bare name, definitions only
*/
`ifndef SLAVE_CTRL_DEFS_VH
`define SLAVE_CTRL_DEFS_VH

`define OFF_SLAVE_CFG 4'h8
`define OFF_ENABLE 4'hC
`define OFF_FLAGS 4'h0
`define OFF_COUNT 4'h4
`define SLAVE_CFG_RESET 8'h00
`define ENABLE_RESET 15'h0
`define ENABLE_MASK 32'h00005F5F
`define CFG_MASK 32'h000000FF
`define FLAG_MASK 32'h0000005F

`define POS_SMC_LO 0
`define POS_SMC_HI 2
`define POS_COMPARE_CLEAR_SELECT 3
`define POS_TRIGGER_SELECT_LO 4
`define POS_TRIGGER_SELECT_HI 6
`define POS_MSM 7

`define POS_UPDATE_IRQ_ENABLE 0
`define POS_CHIE_LO 1
`define POS_TRIGGER_IRQ_ENABLE 6
`define POS_UPDATE_DMA_ENABLE 8
`define POS_CHDEN_LO 9
`define POS_TRIGGER_DMA_ENABLE 14

`define SMC_DISABLE 3'h0
`define SMC_QUAD0 3'h1
`define SMC_QUAD1 3'h2
`define SMC_QUAD2 3'h3
`define SMC_RESTART 3'h4
`define SMC_PAUSE 3'h5
`define SMC_EVENT 3'h6
`define SMC_EXTCLK0 3'h7

`define TRIGGER_SELECT_CH0_EDGE 3'h4
`define TRIGGER_SELECT_CH0_FILT 3'h5
`define TRIGGER_SELECT_CH1_FILT 3'h6
`define TRIGGER_SELECT_EXT 3'h7

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- design/pin_sync.v
/*
 two-flop synchroniser for a vector of asynchronous inputs
 assumes one clock and a synchronous active-low reset
*/
`timescale 1ns/1ps
module pin_sync #(
    parameter WIDTH = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1;

    always @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

//--- design/timer_slave_mode_trigger_ctrl.v
/*
 slave-mode controller of a 16-bit timer: trigger selection, slave modes,
 quadrature decoding, compare-clear routing, event flags and gating of
 interrupt and dma requests; registers on an axi4-lite slave.
 assumes trigger and capture inputs are asynchronous and are synchronised
 here; channel capture/compare events come from same-clock logic.
*/
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "slave_ctrl_defs.vh"
module timer_slave_mode_trigger_ctrl (
    input wire aclk,
    input wire aresetn,
    input wire [3:0] internal_trigger_in,
    input wire ch0_filtered_input,
    input wire ch1_filtered_input,
    input wire ext_trigger_prescaled,
    input wire ext_trigger_filtered,
    input wire compare_ref_clear_pin,
    input wire [3:0] cc_event,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [15:0] count,
    output reg count_dir_down,
    output reg trigger_input,
    output reg compare_ref_clear_internal,
    output reg update_event,
    output reg irq,
    output reg [5:0] dma_req
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    wire [8:0] sync_q;
    wire [3:0] iti_s;
    wire ch0_s;
    wire ch1_s;
    wire etp_s;
    wire etf_s;

    pin_sync #(.WIDTH(9)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({compare_ref_clear_pin, ext_trigger_filtered, ext_trigger_prescaled,
                   ch1_filtered_input, ch0_filtered_input, internal_trigger_in}),
        .sync_out(sync_q)
    );
    assign iti_s = sync_q[3:0];
    assign ch0_s = sync_q[4];
    assign ch1_s = sync_q[5];
    assign etp_s = sync_q[6];
    assign etf_s = sync_q[7];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [7:0] slave_cfg;
    reg [14:0] dma_irq_enable;
    reg [6:0] flags;
    reg counter_enable_bit;
    reg ch0_prev;
    reg ch1_prev;
    reg trg_prev;

    wire [2:0] slave_mode_code = slave_cfg[`POS_SMC_HI:`POS_SMC_LO];
    wire [2:0] trigger_select = slave_cfg[`POS_TRIGGER_SELECT_HI:`POS_TRIGGER_SELECT_LO];
    wire compare_clear_select = slave_cfg[`POS_COMPARE_CLEAR_SELECT];
    wire sync_start_enable = slave_cfg[`POS_MSM];

    // ------------------------------------------------------------
    // trigger selection
    // ------------------------------------------------------------
    wire ch0_edge_detect = ch0_s ^ ch0_prev;
    reg trg_sel;

    always @* begin
        case (trigger_select)
            `TRIGGER_SELECT_CH0_EDGE: trg_sel = ch0_edge_detect;
            `TRIGGER_SELECT_CH0_FILT: trg_sel = ch0_s;
            `TRIGGER_SELECT_CH1_FILT: trg_sel = ch1_s;
            `TRIGGER_SELECT_EXT: trg_sel = etp_s;
            default: trg_sel = iti_s[trigger_select[1:0]];
        endcase
    end

    wire trg_rise = trg_sel & ~trg_prev;
    wire trg_fall = ~trg_sel & trg_prev;
    wire is_pause = (slave_mode_code == `SMC_PAUSE);
    wire trigger_event = is_pause ? (trg_rise | trg_fall) : trg_rise;

    // ------------------------------------------------------------
    // counting step
    // ------------------------------------------------------------
    wire ch0_edge = ch0_s ^ ch0_prev;
    wire ch1_edge = ch1_s ^ ch1_prev;
    reg step;
    reg step_down;
    reg restart;

    always @* begin
        step = 1'b0;
        step_down = count_dir_down;
        restart = 1'b0;
        case (slave_mode_code)
            `SMC_DISABLE: begin
                step = counter_enable_bit;
            end
            `SMC_QUAD0: begin
                step = ch1_edge;
                step_down = ch1_edge & (ch1_s ^ ch0_s);
            end
            `SMC_QUAD1: begin
                step = ch0_edge;
                step_down = ch0_edge & ~(ch0_s ^ ch1_s);
            end
            `SMC_QUAD2: begin
                step = ch0_edge | ch1_edge;
                step_down = ch0_edge ? ~(ch0_s ^ ch1_s) : (ch1_s ^ ch0_s);
            end
            `SMC_RESTART: begin
                restart = trg_rise;
                step = counter_enable_bit & ~trg_rise;
            end
            `SMC_PAUSE: begin
                step = counter_enable_bit & trg_sel;
            end
            `SMC_EVENT: begin
                step = counter_enable_bit;
            end
            `SMC_EXTCLK0: begin
                step = trg_rise;
            end
            default: begin
                step = 1'b0;
            end
        endcase
    end

    // event mode and sync start both set the enable on a trigger rise
    wire start_evt = trg_rise & ((slave_mode_code == `SMC_EVENT) | sync_start_enable);

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    reg aw_held;
    reg aw_hi_ok;
    reg w_held;
    reg [3:0] aw_idx;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    wire do_write = aw_held & w_held & ~s_axi_bvalid;
    wire [31:0] wr_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    wire [31:0] en_wide = {17'h0, dma_irq_enable};
    wire [31:0] cfg_wide = {24'h000000, slave_cfg};
    wire [31:0] en_next = (en_wide & ~wr_mask) | (w_data & wr_mask & `ENABLE_MASK);
    wire [31:0] cfg_next = (cfg_wide & ~wr_mask) | (w_data & wr_mask & `CFG_MASK);
    wire wr_en = do_write & aw_hi_ok & (aw_idx == `OFF_ENABLE);
    wire wr_cfg = do_write & aw_hi_ok & (aw_idx == `OFF_SLAVE_CFG);
    wire wr_flag = do_write & aw_hi_ok & (aw_idx == `OFF_FLAGS) & w_strb[0];
    wire wr_cnt = do_write & aw_hi_ok & (aw_idx == `OFF_COUNT);
    wire wr_ok = (aw_idx == `OFF_ENABLE) | (aw_idx == `OFF_SLAVE_CFG) |
                 (aw_idx == `OFF_FLAGS) | (aw_idx == `OFF_COUNT);

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            aw_held <= 1'b0;
            aw_hi_ok <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= 4'h0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held <= 1'b1;
                aw_idx <= s_axi_awaddr[3:0];
                aw_hi_ok <= (s_axi_awaddr[31:4] == 28'h0000000);
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_ok && aw_hi_ok) ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    wire [3:0] ar_idx = s_axi_araddr[3:0];
    wire ar_hi_ok = (s_axi_araddr[31:4] == 28'h0000000);
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            if (!ar_hi_ok) begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `RESP_SLVERR;
            end else begin
                case (ar_idx)
                    `OFF_FLAGS: s_axi_rdata <= {25'h0, flags} & `FLAG_MASK;
                    `OFF_COUNT: s_axi_rdata <= {14'h0, counter_enable_bit, count_dir_down, count};
                    `OFF_SLAVE_CFG: s_axi_rdata <= cfg_wide;
                    `OFF_ENABLE: s_axi_rdata <= en_wide;
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `RESP_SLVERR;
                    end
                endcase
            end
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // configuration, counter and flags
    // ------------------------------------------------------------
    wire wrap_up = step & ~step_down & (count == 16'hFFFF);
    wire wrap_dn = step & step_down & (count == 16'h0000);
    wire next_update = restart | wrap_up | wrap_dn;
    wire [6:0] set_flags = {trigger_event, 1'b0, cc_event, next_update};
    wire [6:0] clr_flags = wr_flag ? ~w_data[6:0] : 7'h00;

    always @(posedge aclk) begin
        if (!aresetn) begin
            slave_cfg <= `SLAVE_CFG_RESET;
            dma_irq_enable <= `ENABLE_RESET;
            flags <= 7'h00;
            count <= 16'h0000;
            count_dir_down <= 1'b0;
            counter_enable_bit <= 1'b0;
            ch0_prev <= 1'b0;
            ch1_prev <= 1'b0;
            trg_prev <= 1'b0;
            update_event <= 1'b0;
        end else begin
            ch0_prev <= ch0_s;
            ch1_prev <= ch1_s;
            trg_prev <= trg_sel;
            update_event <= next_update;
            if (wr_cfg) begin
                slave_cfg <= cfg_next[7:0];
            end
            if (wr_en) begin
                dma_irq_enable <= en_next[14:0];
            end
            // set wins over a same-cycle software clear
            flags <= (flags & ~clr_flags) | set_flags;
            if (wr_cnt & w_strb[2]) begin
                counter_enable_bit <= w_data[17];
            end else if (start_evt) begin
                counter_enable_bit <= 1'b1;
            end
            if (restart) begin
                count <= 16'h0000;
            end else if (wr_cnt & w_strb[0] & w_strb[1]) begin
                count <= w_data[15:0];
            end else if (step) begin
                count <= step_down ? count - 16'h0001 : count + 16'h0001;
            end
            if (slave_mode_code == `SMC_QUAD0 || slave_mode_code == `SMC_QUAD1 ||
                slave_mode_code == `SMC_QUAD2) begin
                if (step) begin
                    count_dir_down <= step_down;
                end
            end else if (wr_cnt & w_strb[2]) begin
                count_dir_down <= w_data[16];
            end
        end
    end

    // ------------------------------------------------------------
    // outputs: trigger, clear routing, interrupt and dma gating
    // ------------------------------------------------------------
    wire [3:0] ch_irq_en = dma_irq_enable[`POS_CHIE_LO+3:`POS_CHIE_LO];
    wire [3:0] ch_dma_en = dma_irq_enable[`POS_CHDEN_LO+3:`POS_CHDEN_LO];

    always @(posedge aclk) begin
        if (!aresetn) begin
            trigger_input <= 1'b0;
            compare_ref_clear_internal <= 1'b0;
            irq <= 1'b0;
            dma_req <= 6'h00;
        end else begin
            trigger_input <= trg_sel;
            compare_ref_clear_internal <= compare_clear_select ? etf_s : sync_q[8];
            irq <= (flags[0] & dma_irq_enable[`POS_UPDATE_IRQ_ENABLE]) |
                   (flags[6] & dma_irq_enable[`POS_TRIGGER_IRQ_ENABLE]) |
                   (|(flags[4:1] & ch_irq_en));
            dma_req <= {flags[6] & dma_irq_enable[`POS_TRIGGER_DMA_ENABLE],
                        flags[4:1] & ch_dma_en,
                        flags[0] & dma_irq_enable[`POS_UPDATE_DMA_ENABLE]};
        end
    end
endmodule

//--- verif/slave_ctrl_asserts.sv
/*
 concurrent checks on the ports of the slave-mode controller.
 assumes the port names of the design top; bound below by name.
*/
`timescale 1ns/1ps
`include "slave_ctrl_defs.vh"
module slave_ctrl_asserts (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [15:0] count,
    input wire update_event,
    input wire irq,
    input wire [5:0] dma_req
);
// ----------------------------------------
// handshake and event checks
// ----------------------------------------
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
endsequence
sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
endsequence
chk_reset_idle: assert property (disable iff (1'b0) !aresetn |=> s_axi_awready && s_axi_arready
    && !s_axi_bvalid && !s_axi_rvalid && !irq && dma_req == 6'h00 && count == 16'h0000)
    else $error("outputs not idle after reset");
chk_wr_answer: assert property (s_wr_take |=> ##1 s_axi_bvalid)
    else $error("write response late");
chk_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read data late");
chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
chk_b_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
chk_r_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during response");
chk_bad_read: assert property (s_rd_take ##0 (s_axi_araddr[31:4] != 28'h0000000)
    |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
chk_upd_pulse: assert property (update_event |=> !update_event)
    else $error("update event longer than one cycle");
endmodule
bind timer_slave_mode_trigger_ctrl slave_ctrl_asserts u_chk (.*);

//--- verif/trig_partner.sv
/*
 far-side model: master timer trigger links and filtered pins.
 assumes the bench calls drive and pulse; changes only after aclk rises.
*/
`timescale 1ns/1ps
module trig_partner (
    input wire aclk,
    output wire [3:0] internal_trigger_in,
    output wire ch0_filtered_input,
    output wire ch1_filtered_input,
    output wire ext_trigger_prescaled,
    output wire ext_trigger_filtered,
    output wire compare_ref_clear_pin
);
// ----------------------------------------
// line drive
// ----------------------------------------
logic [8:0] lines = 9'h0;
assign {compare_ref_clear_pin, ext_trigger_filtered, ext_trigger_prescaled} = lines[8:6];
assign {ch1_filtered_input, ch0_filtered_input, internal_trigger_in} = lines[5:0];
// each level held at least seven cycles, well under a quarter of the kernel rate
task drive(input int k, input logic v);
    @(posedge aclk);
    lines[k] <= v;
    repeat (6) @(posedge aclk);
endtask
task pulse(input int k);
    drive(k, 1'b1);
    drive(k, 1'b0);
endtask
endmodule

//--- verif/tb.sv
/*
 self-checking bench: axi4-lite tasks, trigger partner, mode scenarios.
 assumes a 40 MHz aclk and synchronous active-low reset.
*/
`timescale 1ns/1ps
`include "slave_ctrl_defs.vh"
module tb;
logic aclk;
logic aresetn;
logic [3:0] internal_trigger_in, cc_event, s_axi_wstrb;
logic ch0_filtered_input, ch1_filtered_input, ext_trigger_prescaled, ext_trigger_filtered, compare_ref_clear_pin;
logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, count_dir_down, trigger_input;
logic compare_ref_clear_internal, update_event, irq;
logic [1:0] s_axi_bresp, s_axi_rresp, r;
logic [15:0] count;
logic [5:0] dma_req;
int err_total, tests_run, cyc, i;
trig_partner src (.*);
timer_slave_mode_trigger_ctrl DUT (.*);
// ----------------------------------------
// tasks
// ----------------------------------------
task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
        err_total++;
        $display("BAD %0t got %h want %h", $time, g, e);
    end
endtask
task results;
    if (err_total == 0 && tests_run > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
task wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
endtask
task rd(input logic [31:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
endtask
task mode(input logic [31:0] c);
    wr(`OFF_SLAVE_CFG, 32'h00000000);
    wr(`OFF_SLAVE_CFG, c);
endtask
task cc(input int k);
    @(posedge aclk);
    cc_event <= 4'h1 << k;
    @(posedge aclk);
    cc_event <= 4'h0;
    repeat (3) @(posedge aclk);
endtask
initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
end
always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
        err_total++;
        results;
    end
end
// ----------------------------------------
// scenarios
// ----------------------------------------
initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, cc_event} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFF_ENABLE);
    chk(d, 32'h00000000);
    rd(32'h00000010);
    chk(r, `RESP_SLVERR);
    wr(32'h0000001C, 32'h00005F5F);
    chk(r, `RESP_SLVERR);
    rd(`OFF_ENABLE);
    chk(d, 32'h00000000);
    wr(`OFF_ENABLE, 32'h00005F5F);
    chk(r, `RESP_OKAY);
    rd(`OFF_ENABLE);
    chk(d, 32'h00005F5F);
    for (i = 0; i < 4; i++) begin
        wr(`OFF_ENABLE, 32'h1 << (1 + i));
        cc(i);
        chk(irq, 1);
        chk(dma_req, 0);
        wr(`OFF_FLAGS, 32'h0);
        wr(`OFF_ENABLE, 32'h1 << (9 + i));
        cc(i);
        chk(dma_req, 32'h1 << (1 + i));
        chk(irq, 0);
        wr(`OFF_FLAGS, 32'h0);
    end
    for (i = 0; i < 8; i++) if (i != 4) begin
        wr(`OFF_SLAVE_CFG, i << 4);
        src.drive(i < 4 ? i : i - 1, 1'b1);
        chk(trigger_input, 1);
        src.drive(i < 4 ? i : i - 1, 1'b0);
        chk(trigger_input, 0);
    end
    src.drive(8, 1'b1);
    wr(`OFF_SLAVE_CFG, 32'h0);
    repeat (5) @(posedge aclk);
    chk(compare_ref_clear_internal, 1);
    wr(`OFF_SLAVE_CFG, 32'h8);
    repeat (5) @(posedge aclk);
    chk(compare_ref_clear_internal, 0);
    mode(32'h07);
    wr(`OFF_COUNT, 32'h00020000);
    for (i = 0; i < 3; i++) src.pulse(0);
    chk(count, 16'h0003);
    mode(32'h47);
    wr(`OFF_COUNT, 32'h00020000);
    for (i = 0; i < 2; i++) src.pulse(4);
    chk(count, 16'h0004);
    wr(`OFF_ENABLE, 32'h00004141);
    mode(32'h04);
    wr(`OFF_COUNT, 32'h00021234);
    wr(`OFF_FLAGS, 32'h0);
    src.pulse(0);
    chk(count < 16'h0020, 1);
    rd(`OFF_FLAGS);
    chk(d & 32'h41, 32'h41);
    chk(dma_req, 6'h21);
    chk(irq, 1);
    mode(32'h05);
    wr(`OFF_COUNT, 32'h00020100);
    repeat (5) @(posedge aclk);
    chk(count, 16'h0100);
    src.drive(0, 1'b1);
    chk(count > 16'h0100, 1);
    wr(`OFF_FLAGS, 32'h0);
    src.drive(0, 1'b0);
    rd(`OFF_FLAGS);
    chk(d[6], 1);
    mode(32'h06);
    wr(`OFF_COUNT, 32'h00000005);
    src.pulse(0);
    chk(count > 16'h0005, 1);
    mode(32'h90);
    wr(`OFF_COUNT, 32'h00000005);
    repeat (5) @(posedge aclk);
    chk(count, 16'h0005);
    src.pulse(1);
    chk(count > 16'h0005, 1);
    for (i = 1; i < 4; i++) begin
        mode(i);
        wr(`OFF_COUNT, 32'h00020064);
        src.drive(i == 2 ? 4 : 5, i != 3);
        chk(count, 16'h0063);
        chk(count_dir_down, 1);
    end
    results;
end
endmodule
